// ===== rtl/sscs_pkg.sv
package sscs_pkg;

  // ****************************************
  // widths and limits
  // ****************************************
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned FIELD_W    = 10;
  localparam int unsigned FACTOR_W   = 11;
  localparam int unsigned PIN_COUNT  = 5;

  localparam logic [FACTOR_W-1:0] FACTOR_ONE = 11'h001;
  localparam logic [FACTOR_W-1:0] FACTOR_MAX = 11'h400;
  localparam logic [FIELD_W-1:0]  COUNT_ZERO = 10'h000;

  // ****************************************
  // synchroniser bit positions
  // ****************************************
  localparam int unsigned PIN_DIRECT  = 0;
  localparam int unsigned PIN_CRYSTAL = 1;
  localparam int unsigned PIN_INTERN  = 2;
  localparam int unsigned PIN_LOOP    = 3;
  localparam int unsigned PIN_WAKEUP  = 4;

  // ****************************************
  // source selector codes
  // ****************************************
  typedef enum logic [SEL_W-1:0] {
    SSCS_SRC_WAKEUP   = 2'h0,
    SSCS_SRC_RESERVED = 2'h1,
    SSCS_SRC_DIVIDED  = 2'h2,
    SSCS_SRC_DIRECT   = 2'h3
  } sscs_src_t;

  localparam sscs_src_t RESET_SOURCE = SSCS_SRC_WAKEUP;

endpackage

// ===== rtl/sscs_sync.sv
`timescale 1ns/1ps

module sscs_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          stage_one[i] <= 1'b0;
          sync_out[i]  <= 1'b0;
        end
        else
        begin
          stage_one[i] <= async_in[i];
          sync_out[i]  <= stage_one[i];
        end
      end
    end
  endgenerate

endmodule

// ===== rtl/sscs_clock_select.sv
`timescale 1ns/1ps

module sscs_clock_select
  import sscs_pkg::*;
(
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  // clock source pins
  input  wire logic                         direct_clock_input_pin,
  input  wire logic                         crystal_input_pin,
  input  wire logic                         internal_clock_source,
  input  wire logic                         loop_clock_output,
  input  wire logic                         wakeup_clock_source,
  // control settings
  input  wire logic [sscs_pkg::SEL_W-1:0]   clock_source_select,
  input  wire logic                         oscillator_bypass,
  input  wire logic                         prescaler_use_internal,
  input  wire logic [sscs_pkg::FIELD_W-1:0] prescaler_divide_field,
  // clock results
  output logic                              system_clock,
  output logic                              system_clock_tick,
  output logic                              loop_enable,
  output logic [sscs_pkg::SEL_W-1:0]        active_source
);

  import sscs_pkg::*;

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [PIN_COUNT-1:0] pins_sync;

  sscs_sync #(
    .WIDTH (PIN_COUNT)
  ) i_sscs_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({wakeup_clock_source, loop_clock_output, internal_clock_source,
                crystal_input_pin, direct_clock_input_pin}),
    .sync_out (pins_sync)
  );

  wire direct_s = pins_sync[PIN_DIRECT];
  wire crystal_s = pins_sync[PIN_CRYSTAL];
  wire intern_s = pins_sync[PIN_INTERN];
  wire loop_s = pins_sync[PIN_LOOP];
  wire wakeup_s = pins_sync[PIN_WAKEUP];

  // ****************************************
  // source selection
  // ****************************************
  sscs_src_t source;
  logic      osc_prev;
  logic [FIELD_W-1:0] div_count;

  wire sscs_src_t next_source = (clock_source_select == SSCS_SRC_RESERVED) ? source
                                : sscs_src_t'(clock_source_select);
  wire osc_s = prescaler_use_internal ? intern_s : crystal_s;
  wire osc_rise = osc_s & ~osc_prev;
  wire divided_mode = (source == SSCS_SRC_DIVIDED) & oscillator_bypass;
  wire loop_mode = (source == SSCS_SRC_DIVIDED) & ~oscillator_bypass;

  wire [FACTOR_W-1:0] factor = {1'b0, prescaler_divide_field} + FACTOR_ONE;
  wire [FACTOR_W-1:0] high_span = (factor + FACTOR_ONE) >> 1;
  wire [FACTOR_W-1:0] count_ext = {1'b0, div_count};
  wire                count_last = (count_ext == (factor - FACTOR_ONE));
  // clamp after field drop
  // a field lowered mid-count must not run the count up to its top
  wire                count_over = (count_ext >= factor);
  wire divided_level = (factor == FACTOR_ONE) ? osc_s : (count_ext < high_span);

  logic next_clock;
  always_comb
  begin
    unique case (source)
      SSCS_SRC_DIRECT:  next_clock = direct_s;
      SSCS_SRC_DIVIDED: next_clock = oscillator_bypass ? divided_level : loop_s;
      SSCS_SRC_WAKEUP:  next_clock = wakeup_s;
      default:          next_clock = wakeup_s;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      source <= RESET_SOURCE;
      osc_prev <= 1'b0;
    end
    else
    begin
      source <= next_source;
      osc_prev <= osc_s;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      div_count <= COUNT_ZERO;
    else if (!divided_mode || factor == FACTOR_ONE)
      div_count <= COUNT_ZERO;
    else if (count_over)
      div_count <= COUNT_ZERO;
    else if (osc_rise)
      div_count <= count_last ? COUNT_ZERO : div_count + 10'h001;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      system_clock      <= 1'b0;
      system_clock_tick <= 1'b0;
      loop_enable       <= 1'b0;
    end
    else
    begin
      system_clock      <= next_clock;
      system_clock_tick <= next_clock & ~system_clock;
      loop_enable       <= (next_source == SSCS_SRC_DIVIDED) & ~oscillator_bypass;
    end
  end

  assign active_source = source;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence direct_held_s;
    (source == SSCS_SRC_DIRECT) [*2];
  endsequence

  direct_pass_a: assert property (direct_held_s |-> system_clock == $past(direct_s))
    else $error("direct clock not passed through");

  osc_route_a: assert property (divided_mode && factor == FACTOR_ONE ##1 divided_mode && factor == FACTOR_ONE
                                |-> system_clock == $past(prescaler_use_internal ? intern_s : crystal_s))
    else $error("prescaler input routed wrongly");

  divide_wrap_a: assert property (divided_mode && factor != FACTOR_ONE && osc_rise && count_last
                                  ##1 divided_mode |-> div_count == COUNT_ZERO)
    else $error("divider did not wrap at factor");

  count_bound_a: assert property (divided_mode |=> count_ext < $past(factor))
    else $error("divider count beyond factor");

  count_clamp_a: assert property (divided_mode && count_over |=> div_count == COUNT_ZERO)
    else $error("divider count not cleared after field drop");

  unit_pass_a: assert property ((divided_mode && factor == FACTOR_ONE) [*2] |-> system_clock == $past(osc_s))
    else $error("factor one not passed through");

  max_factor_a: assert property (prescaler_divide_field == 10'h3FF |-> factor == FACTOR_MAX)
    else $error("largest factor not 1024");

  max_wrap_a: assert property (divided_mode && prescaler_divide_field == {FIELD_W{1'b1}} && osc_rise
                               && div_count == {FIELD_W{1'b1}} |=> div_count == COUNT_ZERO)
    else $error("divider did not wrap at largest factor");

  crystal_pass_a: assert property ((divided_mode && factor == FACTOR_ONE && !prescaler_use_internal) [*2]
                                   |-> system_clock == $past(crystal_s))
    else $error("crystal bypass not undivided");

  loop_use_a: assert property ((loop_mode && clock_source_select == SSCS_SRC_DIVIDED) [*2]
                               |-> loop_enable && system_clock == $past(loop_s))
    else $error("loop output not selected");

  loop_off_a: assert property (source != SSCS_SRC_DIVIDED |-> !loop_enable)
    else $error("loop enabled outside loop mode");

  wakeup_pass_a: assert property ((source == SSCS_SRC_WAKEUP) [*2] |-> system_clock == $past(wakeup_s))
    else $error("wakeup clock not passed through");

  idle_count_a: assert property (!divided_mode |=> div_count == COUNT_ZERO)
    else $error("divider counting outside prescaler mode");

  reserved_hold_a: assert property (clock_source_select == SSCS_SRC_RESERVED |=> $stable(source))
    else $error("reserved selector changed source");

  reserved_loop_a: assert property ((source == SSCS_SRC_DIVIDED && !oscillator_bypass
                                     && clock_source_select == SSCS_SRC_RESERVED) |=> loop_enable)
    else $error("reserved selector dropped loop enable");

endmodule

// ===== tb/tb_system_clock_source_select.sv
`timescale 1ns/1ps

module tb_system_clock_source_select;
  import sscs_pkg::*;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       direct_pin = 1'b0, crystal_pin = 1'b0, internal_src = 1'b0, loop_out = 1'b0, wakeup_src = 1'b0;
  logic [1:0] sel = 2'h0;
  logic       bypass = 1'b0, use_int = 1'b0;
  logic [9:0] field = 10'h000;
  logic       system_clock, system_clock_tick, loop_enable;
  logic [1:0] active_source;
  int         cyc = 0, n_fail = 0, cmp_count = 0;

  sscs_clock_select i_sscs_clock_select (.clk_sys(clk_sys), .reset(reset), .direct_clock_input_pin(direct_pin),
    .crystal_input_pin(crystal_pin), .internal_clock_source(internal_src), .loop_clock_output(loop_out),
    .wakeup_clock_source(wakeup_src), .clock_source_select(sel), .oscillator_bypass(bypass),
    .prescaler_use_internal(use_int), .prescaler_divide_field(field), .system_clock(system_clock),
    .system_clock_tick(system_clock_tick), .loop_enable(loop_enable), .active_source(active_source));

  // ****************************************
  // clock and source generators
  // ****************************************
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // periods in clk_sys cycles: direct 8, crystal 8, internal 6, loop 10, wakeup 12
  initial
  begin
    forever
    begin
      @(posedge clk_sys);
      #1;
      cyc++;
      direct_pin = cyc[2];
      crystal_pin = ~cyc[2];
      internal_src = (cyc % 6) < 3;
      loop_out = (cyc % 10) < 5;
      wakeup_src = (cyc % 12) < 6;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic set(input logic [1:0] s, input logic b, input logic u, input logic [9:0] f);
    @(posedge clk_sys);
    #1;
    sel = s;
    bypass = b;
    use_int = u;
    field = f;
    repeat (10) @(posedge clk_sys);
    #2;
  endtask

  // skips one full period, then counts period and high time of system_clock
  task automatic measure(input int exp_per, input int exp_hi, input string what);
    int per = 0;
    int hi = 0;
    int k = 0;
    repeat (2)
    begin
      do
      begin
        @(posedge clk_sys);
        #2;
        k++;
      end
      while (system_clock_tick !== 1'b1 && k < 30000);
    end
    do
    begin
      if (system_clock === 1'b1) hi++;
      per++;
      @(posedge clk_sys);
      #2;
    end while (system_clock_tick !== 1'b1 && per < 30000);
    chk(exp_per, per, {what, " period"});
    chk(exp_hi, hi, {what, " high"});
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_direct();
    set(2'h3, 1'b1, 1'b1, 10'h005);
    chk(2'h3, active_source, "active_source");
    chk(0, loop_enable, "loop_enable");
    measure(8, 4, "direct");
    $display("test direct done");
  endtask

  task automatic t_factor_one();
    set(2'h2, 1'b1, 1'b0, 10'h000);
    measure(8, 4, "crystal div1");
    set(2'h2, 1'b1, 1'b1, 10'h000);
    measure(6, 3, "internal div1");
    $display("test factor one done");
  endtask

  task automatic t_div3();
    int k = 0;
    set(2'h2, 1'b1, 1'b1, 10'h3ff);
    repeat (30) @(posedge clk_sys);
    set(2'h2, 1'b1, 1'b1, 10'h002);
    do
    begin
      @(posedge clk_sys);
      #2;
      k++;
    end
    while (system_clock_tick !== 1'b1 && k < 30);
    chk(1, system_clock_tick, "div3 settle tick");
    measure(18, 12, "internal div3");
    $display("test div3 done");
  endtask

  task automatic t_max();
    set(2'h2, 1'b1, 1'b0, 10'h3ff);
    measure(8192, 4096, "crystal div1024");
    $display("test max done");
  endtask

  task automatic t_loop();
    set(2'h2, 1'b0, 1'b1, 10'h003);
    chk(1, loop_enable, "loop_enable");
    measure(10, 5, "loop");
    $display("test loop done");
  endtask

  task automatic t_reset();
    set(2'h1, 1'b0, 1'b1, 10'h003);
    chk(2'h2, active_source, "reserved active_source");
    chk(1, loop_enable, "reserved loop_enable");
    @(posedge clk_sys);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2;
    chk(0, system_clock, "reset system_clock");
    chk(0, system_clock_tick, "reset tick");
    chk(0, loop_enable, "reset loop_enable");
    chk(2'h0, active_source, "reset active_source");
    @(posedge clk_sys);
    #1;
    reset = 1'b0;
    repeat (10) @(posedge clk_sys);
    #2;
    chk(2'h0, active_source, "released active_source");
    measure(12, 6, "wakeup after reset");
    $display("test reset done");
  endtask

  task automatic t_wake();
    set(2'h0, 1'b1, 1'b1, 10'h003);
    chk(2'h0, active_source, "active_source");
    measure(12, 6, "wakeup");
    $display("test wakeup done");
  endtask

  task automatic t_reserved();
    set(2'h3, 1'b0, 1'b0, 10'h000);
    set(2'h1, 1'b0, 1'b0, 10'h000);
    chk(2'h3, active_source, "active_source");
    chk(0, loop_enable, "loop_enable");
    measure(8, 4, "reserved");
    $display("test reserved done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_wake();
    t_direct();
    t_factor_one();
    t_div3();
    t_loop();
    t_reset();
    t_reserved();
    t_max();
    end_sim();
  end

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end

endmodule
